// ==== design/mac_port.sv ====
// mii / rmii transmit and receive port logic with an axi4-lite register slave
// assumes aclk is the system reference clock, also used as the rmii reference
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "mac_port_regs.svh"
module mac_port
	import mac_port_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        tx_clk_i,
	output logic             tx_clk_o,
	output logic             tx_clk_oe,
	output logic [3:0]       txd,
	output logic             tx_en,
	input  wire logic        rx_clk,
	input  wire logic [3:0]  rxd,
	input  wire logic        rx_dv,
	input  wire logic        rx_err,
	input  wire logic        crs,
	input  wire logic        col
);
	mac_st_s s_r;
	mac_st_s s_nxt;
	pins_s   pin_raw;
	pins_s   p;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [3:0] wrap(input logic [3:0] cnt, input logic [3:0] lim);
		return (cnt >= lim - 4'h1) ? 4'h0 : cnt + 4'h1;
	endfunction : wrap

	function automatic logic [7:0] src_byte(input logic [3:0] idx, input logic [63:0] pay);
		logic [3:0] k;
		k = idx - `HDR_BYTES;
		if (idx < `HDR_BYTES - 4'h1) begin
			return `PRE_BYTE;
		end else if (idx == `HDR_BYTES - 4'h1) begin
			return `SFD_BYTE;
		end
		return pay[{k[2:0], 3'h0} +: 8];
	endfunction : src_byte

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pin_raw = '{rxd: rxd, rx_err: rx_err, rx_dv: rx_dv, col: col, crs: crs,
		rx_clk: rx_clk, tx_clk: tx_clk_i};

	pin_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.d       (pin_raw),
		.q       (p)
	);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		logic        rmii;
		logic        fast;
		logic        half;
		logic        dce;
		logic [5:0]  unit;
		logic        tx_tick;
		logic        rx_tick;
		logic        busy_line;
		logic        col_ok;
		logic        dv_ok;
		logic [3:0]  len;
		logic [3:0]  end_idx;
		logic [4:0]  expo;
		logic [9:0]  mask;
		logic [31:0] rd;
		logic [8:0]  slot_ticks;
		n_init();
		rmii      = s_r.ctrl[`CTRL_RMII];
		fast      = s_r.ctrl[`CTRL_SPD100];
		half      = s_r.ctrl[`CTRL_HALF];
		dce       = s_r.ctrl[`CTRL_DCE];
		unit      = rmii ? 6'h2 : 6'h4;
		tx_tick   = 1'b0;
		rx_tick   = 1'b0;
		len       = s_r.ctrl[`CTRL_LEN_LSB +: 4];
		end_idx   = `HDR_BYTES + ((len > `MAX_PAYLOAD) ? `MAX_PAYLOAD : len);
		expo      = (s_r.attempts > `BACKOFF_EXP) ? `BACKOFF_EXP : s_r.attempts;
		mask      = 10'((11'h1 << expo) - 11'h1);
		slot_ticks = 9'(`SLOT_BITS / (rmii ? 2 : 4));
		rd        = 32'h0;
		busy_line = half && p.crs;
		col_ok    = half && p.col;
		dv_ok     = p.rx_dv && !(!rmii && !dce && p.rx_err);

		// free-running back-off source
		s_nxt.lfsr = {s_r.lfsr[14:0], ~(s_r.lfsr[15] ^ s_r.lfsr[14] ^ s_r.lfsr[12] ^ s_r.lfsr[3])};

		s_nxt.tx_clk_q = p.tx_clk;
		if (rmii) begin
			s_nxt.rtx_div = fast ? 4'h0 : wrap(s_r.rtx_div, 4'(`RMII10_DIV));
			tx_tick = fast || (s_r.rtx_div == 4'(`RMII10_DIV - 1));
		end else if (dce) begin
			s_nxt.dce_cnt = wrap(s_r.dce_cnt, fast ? 4'(`HALF100) : 4'(`HALF10));
			if (s_nxt.dce_cnt == 4'h0) begin
				s_nxt.tx_clk_o = !s_r.tx_clk_o;
				tx_tick = !s_r.tx_clk_o;
			end
		end else begin
			tx_tick = p.tx_clk && !s_r.tx_clk_q;
		end

		s_nxt.rx_clk_q = p.rx_clk;
		if (rmii) begin
			s_nxt.rrx_div = fast ? 4'h0 : wrap(s_r.rrx_div, 4'(`RMII10_DIV));
			rx_tick = fast || (s_r.rrx_div == 4'(`RMII10_DIV - 1));
		end else begin
			rx_tick = p.rx_clk && !s_r.rx_clk_q;
		end

		// axi write: address and data taken in either order
		if (awvalid && s_r.awready) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.awaddr  = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata  = wdata;
			s_nxt.wstrb  = wstrb;
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = `RESP_OKAY;
			unique case (s_r.awaddr)
				`CTRL_OFS: s_nxt.ctrl = merge(s_r.ctrl, s_r.wdata, s_r.wstrb);
				`DATA0_OFS: s_nxt.data0 = merge(s_r.data0, s_r.wdata, s_r.wstrb);
				`DATA1_OFS: s_nxt.data1 = merge(s_r.data1, s_r.wdata, s_r.wstrb);
				`STAT_OFS: begin
					// write one to clear; later sets win
					if (s_r.wstrb[0]) begin
						s_nxt.done   = s_r.done && !s_r.wdata[`ST_DONE];
						s_nxt.abort  = s_r.abort && !s_r.wdata[`ST_ABORT];
						s_nxt.rx_new = s_r.rx_new && !s_r.wdata[`ST_RXNEW];
					end
				end
				default: s_nxt.bresp = `RESP_DECERR;
			endcase
		end
		// one write in flight: nothing new taken while the response waits
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;

		// axi read
		rd[`ST_BUSY]               = s_r.tx_st != TX_IDLE;
		rd[`ST_DONE]               = s_r.done;
		rd[`ST_ABORT]              = s_r.abort;
		rd[`ST_RXACT]              = s_r.rx_act;
		rd[`ST_RXNEW]              = s_r.rx_new;
		rd[`ST_ATT_LSB +: 5]       = s_r.attempts;
		rd[`ST_RXB_LSB +: 8]       = s_r.rx_byte;
		rd[`ST_RXN_LSB +: 8]       = s_r.rx_num;
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid  = 1'b0;
			s_nxt.arready = 1'b1;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid  = 1'b1;
			s_nxt.rresp   = `RESP_OKAY;
			unique case (araddr)
				`CTRL_OFS: s_nxt.rdata = s_r.ctrl;
				`DATA0_OFS: s_nxt.rdata = s_r.data0;
				`DATA1_OFS: s_nxt.rdata = s_r.data1;
				`STAT_OFS: s_nxt.rdata = rd;
				default: begin
					s_nxt.rdata = 32'h0;
					s_nxt.rresp = `RESP_DECERR;
				end
			endcase
		end
		// address taken whenever no read data waits
		s_nxt.arready = !s_nxt.rvalid;

		// transmit sequencer
		unique case (s_r.tx_st)
			TX_IDLE: begin
				if (s_r.ctrl[`CTRL_GO]) begin
					s_nxt.ctrl[`CTRL_GO] = 1'b0;
					s_nxt.attempts = 5'h0;
					s_nxt.tx_st    = TX_DEFER;
				end
			end
			TX_DEFER: begin
				if (tx_tick && !busy_line) begin
					s_nxt.tx_st    = TX_SEND;
					s_nxt.idx      = 4'h0;
					s_nxt.rem      = 6'h0;
					s_nxt.attempts = s_r.attempts + 5'h1;
				end
			end
			TX_SEND: begin
				if (tx_tick && col_ok) begin
					s_nxt.tx_st = TX_JAM;
					s_nxt.sh    = `JAM_PATTERN;
					s_nxt.rem   = 6'(32);
				end
			end
			TX_JAM: begin
				if (tx_tick && s_r.rem == 6'h0) begin
					s_nxt.tx_en = 1'b0;
					if (s_r.attempts >= `MAX_ATTEMPTS) begin
						s_nxt.abort = 1'b1;
						s_nxt.tx_st = TX_IDLE;
					end else begin
						s_nxt.slots    = s_r.lfsr[9:0] & mask;
						s_nxt.slot_cnt = 9'h0;
						s_nxt.tx_st    = TX_BACKOFF;
					end
				end
			end
			TX_BACKOFF: begin
				if (s_r.slots == 10'h0) begin
					s_nxt.tx_st = TX_DEFER;
				end else if (tx_tick) begin
					s_nxt.slot_cnt = s_r.slot_cnt + 9'h1;
					if (s_r.slot_cnt == slot_ticks - 9'h1) begin
						s_nxt.slot_cnt = 9'h0;
						s_nxt.slots    = s_r.slots - 10'h1;
					end
				end
			end
			default: s_nxt.tx_st = TX_IDLE;
		endcase

		// emit one unit per tick, lsb first
		if (tx_tick && (s_nxt.tx_st == TX_SEND || s_nxt.tx_st == TX_JAM)) begin
			if (s_nxt.tx_st == TX_SEND && s_nxt.rem == 6'h0) begin
				s_nxt.sh  = {24'h0, src_byte(s_nxt.idx, {s_r.data1, s_r.data0})};
				s_nxt.rem = 6'h8;
				s_nxt.idx = s_nxt.idx + 4'h1;
			end
			if (s_nxt.tx_st == TX_SEND && s_r.rem == 6'h0 && s_r.idx == end_idx
					&& s_r.tx_st == TX_SEND) begin
				s_nxt.tx_en = 1'b0;
				s_nxt.txd   = 4'h0;
				s_nxt.done  = 1'b1;
				s_nxt.tx_st = TX_IDLE;
			end else if (s_nxt.rem != 6'h0) begin
				s_nxt.tx_en = 1'b1;
				s_nxt.txd   = rmii ? {2'h0, s_nxt.sh[1:0]} : s_nxt.sh[3:0];
				s_nxt.sh    = s_nxt.sh >> unit;
				s_nxt.rem   = s_nxt.rem - unit;
			end
		end

		// carrier loss ends reception at once
		if (!dv_ok) begin
			s_nxt.rx_act = 1'b0;
			s_nxt.rx_cnt = 4'h0;
		end else if (rx_tick) begin
			s_nxt.rx_act = 1'b1;
			s_nxt.rx_sh  = rmii ? {p.rxd[1:0], s_r.rx_sh[7:2]} : {p.rxd, s_r.rx_sh[7:4]};
			s_nxt.rx_cnt = s_r.rx_cnt + unit[3:0];
			if (s_nxt.rx_cnt == 4'h8) begin
				s_nxt.rx_cnt  = 4'h0;
				s_nxt.rx_byte = s_nxt.rx_sh;
				s_nxt.rx_num  = s_r.rx_num + 8'h1;
				s_nxt.rx_new  = 1'b1;
			end
		end
	end

	// copy of state before edits
	function automatic void n_init();
		s_nxt = s_r;
	endfunction : n_init

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs straight from state flops; tx_clk_oe decoded from two ctrl bits
	// ----------------------------------------
	assign awready   = s_r.awready;
	assign wready    = s_r.wready;
	assign bvalid    = s_r.bvalid;
	assign bresp     = s_r.bresp;
	assign arready   = s_r.arready;
	assign rvalid    = s_r.rvalid;
	assign rdata     = s_r.rdata;
	assign rresp     = s_r.rresp;
	assign txd       = s_r.txd;
	assign tx_en     = s_r.tx_en;
	assign tx_clk_o  = s_r.tx_clk_o;
	// drive tx clock only in dce mii
	assign tx_clk_oe = s_r.ctrl[`CTRL_DCE] & ~s_r.ctrl[`CTRL_RMII];
endmodule : mac_port

// ==== design/pin_sync.sv ====
// three-stage synchroniser for the phy pins
// assumes pins may change at any time relative to aclk
`timescale 1ns/10ps
module pin_sync
	import mac_port_pkg::*;
(
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  ce,
	input  wire pins_s d,
	output pins_s      q
);
	sync_st_s s_r;
	sync_st_s s_nxt;
	pins_s    diff;

	// ----------------------------------------
	// filter: output follows once stage two and three agree
	// ----------------------------------------
	always_comb begin
		s_nxt    = s_r;
		diff     = s_r.s2 ^ s_r.s3;
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.q  = (s_r.s3 & ~diff) | (s_r.q & diff);
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule : pin_sync

// ==== inc/mac_port_pkg.sv ====
// types shared by the mac port and its pin synchroniser
// assumes the register header is on the include path
package mac_port_pkg;
	// ----------------------------------------
	// pin group and states
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] rxd;
		logic       rx_err;
		logic       rx_dv;
		logic       col;
		logic       crs;
		logic       rx_clk;
		logic       tx_clk;
	} pins_s;

	typedef struct packed {
		pins_s s1;
		pins_s s2;
		pins_s s3;
		pins_s q;
	} sync_st_s;

	typedef enum logic [2:0] {TX_IDLE, TX_DEFER, TX_SEND, TX_JAM, TX_BACKOFF} tx_state_e;

	typedef struct packed {
		logic        aw_held;
		logic        w_held;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] ctrl;
		logic [31:0] data0;
		logic [31:0] data1;
		logic        done;
		logic        abort;
		logic        rx_new;
		tx_state_e   tx_st;
		logic [4:0]  attempts;
		logic [3:0]  idx;
		logic [31:0] sh;
		logic [5:0]  rem;
		logic [9:0]  slots;
		logic [8:0]  slot_cnt;
		logic [15:0] lfsr;
		logic [3:0]  txd;
		logic        tx_en;
		logic        tx_clk_o;
		logic [3:0]  dce_cnt;
		logic [3:0]  rtx_div;
		logic [3:0]  rrx_div;
		logic        tx_clk_q;
		logic        rx_clk_q;
		logic [7:0]  rx_sh;
		logic [3:0]  rx_cnt;
		logic        rx_act;
		logic [7:0]  rx_byte;
		logic [7:0]  rx_num;
	} mac_st_s;
endpackage : mac_port_pkg

// ==== inc/mac_port_regs.svh ====
// register map, field positions and timing constants of the mac port
// assumes inclusion by bare name from the main module
`ifndef MAC_PORT_REGS_SVH
`define MAC_PORT_REGS_SVH
// ----------------------------------------
// register byte offsets and response codes
// ----------------------------------------
`define CTRL_OFS     8'h00
`define DATA0_OFS    8'h04
`define DATA1_OFS    8'h08
`define STAT_OFS     8'h0c
`define RESP_OKAY    2'b00
`define RESP_DECERR  2'b11
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_RMII    0
`define CTRL_SPD100  1
`define CTRL_HALF    2
`define CTRL_DCE     3
`define CTRL_GO      4
`define CTRL_LEN_LSB 8
`define ST_BUSY      0
`define ST_DONE      1
`define ST_ABORT     2
`define ST_RXACT     3
`define ST_RXNEW     4
`define ST_ATT_LSB   8
`define ST_RXB_LSB   16
`define ST_RXN_LSB   24
// ----------------------------------------
// frame and timing constants
// ----------------------------------------
`define JAM_PATTERN  32'h5555_5555
`define PRE_BYTE     8'h55
`define SFD_BYTE     8'hd5
`define HDR_BYTES    4'h8
`define MAX_PAYLOAD  4'h8
`define MAX_ATTEMPTS 5'h10
`define BACKOFF_EXP  5'h0a
`define SLOT_BITS    512
`define ACLK_NS      40
`define MII10_NS     400
`define MII100_NS    40
`define HALF10       ((`MII10_NS / `ACLK_NS) / 2)
`define HALF100      (((`MII100_NS / `ACLK_NS) / 2) > 0 ? ((`MII100_NS / `ACLK_NS) / 2) : 1)
`define RMII10_DIV   10
`endif

// ==== test/mac_port_assertions.sv ====
// port checker for the mac port: bus handshakes and transmit pins
// assumes binding to every mac_port instance, one aclk domain
`timescale 1ns/10ps
module mac_port_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic [1:0]  bresp,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic [31:0] rdata,
	input wire logic        rready,
	input wire logic        tx_clk_o,
	input wire logic        tx_clk_oe,
	input wire logic [3:0]  txd,
	input wire logic        tx_en
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// transmit pins
	// ----------------------------------------
	chk_first_unit: assert property (
		$rose(tx_en) |-> txd inside {4'h5, 4'h1})
		else $error("tx_en rose without a preamble unit");
	chk_en_holds: assert property (
		$rose(tx_en) |-> tx_en [*8])
		else $error("tx_en dropped inside the preamble");
	chk_dce_period: assert property (
		$rose(tx_clk_o) && tx_clk_oe |=> (tx_clk_o [*4] ##1 !tx_clk_o) or !tx_clk_o)
		else $error("generated tx clock phase of wrong length");

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	chk_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	chk_rdata_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before rready");
	chk_read_answer: assert property (
		arvalid && arready |=> rvalid)
		else $error("no read answer one cycle after address");
	chk_write_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("no write response after address and data");
	chk_write_block: assert property (
		bvalid |-> !awready && !wready)
		else $error("new write accepted while response pending");
endmodule : mac_port_assertions

bind mac_port mac_port_assertions chk_i (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bresp, .bready, .arvalid, .arready, .rvalid, .rdata, .rready,
	.tx_clk_o, .tx_clk_oe, .txd, .tx_en);

// ==== test/mac_port_test.sv ====
// self-checking bench for the mac port over axi4-lite and a phy model
// assumes the checker is bound by its own file
`timescale 1ns/10ps
module mac_port_test;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire         awready, wready, bvalid, arready, rvalid, tx_clk_o, tx_clk_oe, tx_en;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [3:0]  txd, rxd;
	wire         tx_clk_i, rx_clk, rx_dv, rx_err, crs, col;
	logic        rmii = 0, noise = 0;
	int          div = 1, col_at = 0, n_mismatch = 0, num_checks = 0, cyc = 0;
	logic [31:0] rd_d;
	logic [1:0]  rsp;
	logic [3:0]  exp_q[$];

	mac_port dut (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .tx_clk_i, .tx_clk_o, .tx_clk_oe,
		.txd, .tx_en, .rx_clk, .rxd, .rx_dv, .rx_err, .crs, .col);
	phy_model phy (.aclk, .rmii, .noise, .div, .col_at, .txd, .tx_en, .tx_clk_i,
		.rx_clk, .rxd, .rx_dv, .rx_err, .crs, .col);

	// ----------------------------------------
	// clock, hang limit, report
	// ----------------------------------------
	initial forever #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
		end while (!bvalid);
		rsp = bresp;
		bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 0;
		end while (!rvalid);
		rd_d = rdata;
		rsp = rresp;
		rready <= 0;
	endtask : rd

	// ----------------------------------------
	// frame helpers
	// ----------------------------------------
	task automatic add_byte(input logic [7:0] b);
		for (int j = 0; j < (rmii ? 4 : 2); j++)
			exp_q.push_back(rmii ? 4'((b >> (2 * j)) & 8'h03) : 4'((b >> (4 * j)) & 8'h0f));
	endtask : add_byte
	task automatic frame(input logic [31:0] ctl, input logic [63:0] pay, input int len);
		exp_q = {};
		for (int i = 0; i < 8 + len; i++)
			add_byte(i < 7 ? 8'h55 : (i == 7 ? 8'hd5 : pay[8 * (i - 8) +: 8]));
		wr(8'h04, pay[31:0]);
		wr(8'h08, pay[63:32]);
		phy.units = {};
		phy.bursts = 0;
		wr(8'h00, ctl);
		repeat (500) begin
			rd(8'h0c);
			if (rd_d[1])
				break;
		end
	endtask : frame
	task automatic cmp(input int base);
		check(phy.units.size() - base, exp_q.size());
		for (int i = 0; i < exp_q.size(); i++)
			check(phy.units[base + i], exp_q[i]);
	endtask : cmp
	task automatic rx_chk(input logic [7:0] b, input int n, input logic e, input logic [15:0] x);
		phy.rx_send(b, n, e);
		repeat (8) @(posedge aclk);
		rd(8'h0c);
		check({rd_d[31:16], rd_d[3]}, {x, 1'b0});
	endtask : rx_chk

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(8'h0c);
		check(rd_d, 32'h0);
		rd(8'h10);
		check({rsp, rd_d}, {2'b11, 32'h0});
		wr(8'h10, 32'hffff_ffff);
		check(rsp, 2'b11);
		$display("test registers done");
		noise = 1;
		frame(32'h0000_0210, 64'ha53c, 2);
		cmp(0);
		check(rd_d[12:8], 5'h01);
		noise = 0;
		wr(8'h0c, 32'h16);
		$display("test mii transmit done");
		rmii = 1;
		div = 10;
		frame(32'h0000_0111, 64'hc6, 1);
		cmp(0);
		check(phy.hold_err, 0);
		wr(8'h0c, 32'h16);
		$display("test rmii slow transmit done");
		div = 1;
		col_at = 40;
		frame(32'h0000_0817, 64'h0, 8);
		check(phy.bursts, 2);
		check(rd_d[12:8], 5'h02);
		cmp(phy.units.size() - 64);
		check(phy.units[32], 4'h0);
		check(phy.units[phy.units.size() - 81], 4'h0);
		for (int i = 1; i <= 16; i++)
			check(phy.units[phy.units.size() - 64 - i], 4'h1);
		col_at = 0;
		rmii = 0;
		wr(8'h0c, 32'h16);
		$display("test collision done");
		wr(8'h00, 32'h0);
		rx_chk(8'ha7, 2, 0, 16'h01a7);
		rx_chk(8'h3c, 2, 1, 16'h01a7);
		rx_chk(8'h5e, 1, 0, 16'h01a7);
		wr(8'h00, 32'h1);
		rmii = 1;
		div = 10;
		rx_chk(8'h96, 4, 0, 16'h0296);
		$display("test receive done");
		rmii = 0;
		wr(8'h00, 32'h8);
		repeat (30) @(posedge aclk);
		check(tx_clk_oe, 1'b1);
		@(negedge aclk);
		rd_d[0] = tx_clk_o;
		repeat (5) @(negedge aclk);
		check(tx_clk_o, !rd_d[0]);
		repeat (5) @(negedge aclk);
		check(tx_clk_o, rd_d[0]);
		$display("test dce clock done");
		summarize();
	end
endmodule : mac_port_test

// ==== test/phy_model.sv ====
// phy stand-in: transmit clock, unit capture, carrier, receive stimulus
// assumes aclk is the 25 MHz bench clock
`timescale 1ns/10ps
module phy_model (
	input  wire logic       aclk,
	input  wire logic       rmii,
	input  wire logic       noise,
	input  int              div,
	input  int              col_at,
	input  wire logic [3:0] txd,
	input  wire logic       tx_en,
	output logic            tx_clk_i,
	output logic            rx_clk,
	output logic [3:0]      rxd,
	output logic            rx_dv,
	output logic            rx_err,
	output logic            crs,
	output logic            col
);
	logic [3:0] units[$];
	logic [3:0] last;
	int         ucnt = 0;
	int         bursts = 0;
	int         hold_err = 0;
	int         colc = 0;
	bit         col_done = 0;
	wire        cap_clk = rmii ? aclk : tx_clk_i;

	// free tx clock, ten aclk period; rx error low until rx_send drives it
	initial begin
		tx_clk_i = 0;
		rx_clk = 0;
		rxd = 4'h0;
		rx_dv = 0;
		rx_err = 0;
		crs = 0;
		col = 0;
		forever begin
			repeat (5) @(negedge aclk);
			tx_clk_i = ~tx_clk_i;
		end
	end

	// one unit per tick, count changes between ticks
	always @(posedge cap_clk) begin
		if (tx_en) begin
			if (ucnt % div == 0)
				units.push_back(txd);
			else if (txd != last)
				hold_err++;
			last = txd;
			ucnt++;
		end else if (ucnt > 0) begin
			bursts++;
			ucnt = 0;
		end
	end

	// carrier on any activity, one collision pulse on request
	always @(negedge aclk) begin
		if (col_at == 0)
			col_done = 0;
		else if (!col_done && units.size() == col_at) begin
			col_done = 1;
			colc = 4;
		end
		col = noise || colc > 0;
		crs = noise || tx_en || rx_dv || colc > 0;
		if (colc > 0)
			colc--;
	end

	// n units of b, low first, then lines released
	task automatic rx_send(input logic [7:0] b, input int n, input logic err);
		for (int i = 0; i < n; i++) begin
			@(negedge aclk);
			rx_dv = 1;
			rx_err = err;
			rxd = rmii ? 4'((b >> (2 * i)) & 8'h03) : 4'((b >> (4 * i)) & 8'h0f);
			if (rmii)
				repeat (div - 1) @(negedge aclk);
			else begin
				repeat (5) @(negedge aclk);
				rx_clk = 1;
				repeat (4) @(negedge aclk);
				rx_clk = 0;
			end
		end
		@(negedge aclk);
		rx_dv = 0;
		rx_err = 0;
		rxd = ~rxd;
	endtask : rx_send
endmodule : phy_model
